// ---- rtl/htr_defs.svh ----
// constants of the host transmit-data, tone and interrupt register bank
// assumes one 16-bit register port on REF_CLK and byte-wide modem transfers
`ifndef HTR_DEFS_SVH
`define HTR_DEFS_SVH

`define HTR_ADDR_STATUS   8'hc6
`define HTR_ADDR_RSVD     8'hc7
`define HTR_ADDR_PROG     8'hc8
`define HTR_ADDR_TXD      8'hca
`define HTR_ADDR_TONE     8'hcd
`define HTR_ADDR_MASK     8'hce

`define HTR_REG_RESET     16'h0000

`define HTR_TXD_CONT      10
`define HTR_TXD_APPEND    9
`define HTR_TXD_LAST      8
`define HTR_TONE_MSB      11

`define HTR_MASK_GATE     15
`define HTR_ST_IRQ        15
`define HTR_ST_SELCALL    13
`define HTR_ST_TXEND      7
`define HTR_ST_DREQ       6
`define HTR_ST_PROG       0
`define HTR_EVENT_BITS    16'h2fd9

`define HTR_REF_PERIOD_PS 4000
`define HTR_TONE_HZ_PER_LSB 1
`define HTR_CLK_HZ        (64'he8d4a51000 / `HTR_REF_PERIOD_PS)

`endif

// ---- rtl/htr_pkg.sv ----
// types used only by the register bank, not by its checksum unit
// assumes the constants of htr_defs.svh
package htr_pkg;

   typedef enum logic [2:0] {
      HTR_L_IDLE   = 3'b000,
      HTR_L_DATA   = 3'b001,
      HTR_L_CRC_HI = 3'b010,
      HTR_L_CRC_LO = 3'b011,
      HTR_L_HANG   = 3'b100
   } htr_lstate_type;

   typedef logic [15:0] htr_word_type;

endpackage : htr_pkg

// ---- rtl/htr_crc.sv ----
// byte-wise crc and parity accumulator, msb first
// assumes feed and clear come from the clock domain that drives clk
`timescale 1ns/1ps
`default_nettype none

module htr_crc #(
   parameter int          WIDTH = 15,
   parameter logic [14:0] POLY  = 15'h6815
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             feed,
   input  wire logic             clear,
   input  wire logic [7:0]       data,
   output logic      [WIDTH-1:0] crc_r,
   output logic                  par_r
);

   function automatic logic [WIDTH-1:0] crc_step(input logic [WIDTH-1:0] c,
                                                 input logic [7:0] d);
      logic [WIDTH-1:0] v;
      logic             fb;
      v = c;
      for (int i = 7; i >= 0; i--) begin
         fb = d[i] ^ v[WIDTH-1];
         v  = {v[WIDTH-2:0], 1'b0} ^ (fb ? POLY[WIDTH-1:0] : '0);
      end
      return v;
   endfunction : crc_step

   wire [WIDTH-1:0] base_crc = clear ? '0 : crc_r;
   wire             base_par = clear ? 1'b0 : par_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         crc_r <= '0;
         par_r <= 1'b0;
      end else if (feed) begin
         crc_r <= crc_step(base_crc, data);
         par_r <= base_par ^ (^data);
      end
   end

   // a cleared feed must not depend on earlier state
   clear_restart_a: assert property (@(posedge clk) disable iff (rst)
      (feed && clear && data == 8'h00) |=> (crc_r == '0 && !par_r))
      else $error("crc not restarted by clear");

endmodule : htr_crc

`default_nettype wire

// ---- rtl/htr_regs.sv ----
// host write-only registers: transmit byte control, tone, interrupt enables
// assumes a decoded 16-bit register port on REF_CLK; modem bits leave on MOD_CLK
`timescale 1ns/1ps
`default_nettype none
`include "htr_defs.svh"

module htr_regs #(
   parameter logic [14:0] CRC_POLY = 15'h6815
) (
   input  wire logic        REF_CLK,
   input  wire logic        SRST,
   input  wire logic        MOD_CLK,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   input  wire logic        MSK_TX_ENABLE,
   input  wire logic        TONE_ENABLE,
   input  wire logic [15:0] EVENT_SET,
   input  wire logic        RX_BYTE_VALID,
   input  wire logic [7:0]  RX_BYTE,
   output logic      [14:0] RX_CHECK_CRC,
   output logic             RX_CHECK_PARITY,
   output logic      [15:0] PROG_WORD,
   output logic             PROG_STROBE,
   output logic      [1:0]  TONE_LEVEL,
   output logic             MODULATOR_OUTPUTS,
   output logic             MOD_ACTIVE,
   output logic             HOST_INTERRUPT_LINE_N
);

   localparam logic [27:0] CLK_HZ  = 28'(`HTR_CLK_HZ);
   localparam logic [27:0] HALF_HZ = 28'(`HTR_CLK_HZ / 2);

   function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] r);
      return wr && (a == r);
   endfunction : hit

   // ---------------- register port, REF_CLK ----------------
   wire wr_prog = hit(REG_WR, REG_ADDR, `HTR_ADDR_PROG);
   wire wr_txd  = hit(REG_WR, REG_ADDR, `HTR_ADDR_TXD);
   wire wr_tone = hit(REG_WR, REG_ADDR, `HTR_ADDR_TONE);
   wire wr_mask = hit(REG_WR, REG_ADDR, `HTR_ADDR_MASK);
   wire rd_stat = hit(REG_RD, REG_ADDR, `HTR_ADDR_STATUS);

   htr_pkg::htr_word_type txd_r, tone_r, mask_r, stat_r, stat_nxt;
   logic [10:0] stage_r;
   logic        load_tgl_r, dirty_r;
   logic        ack_m_r, ack_s_r;
   logic        req_m_r, req_s_r, req_p_r;
   logic        end_m_r, end_s_r, end_p_r;
   logic        en_ref_r, irq_n_r, prog_stb_r;
   logic [15:0] rdata_r, prog_r;

   // writes to the reserved address fall through every decode
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         txd_r  <= `HTR_REG_RESET;
         tone_r <= `HTR_REG_RESET;
         mask_r <= `HTR_REG_RESET;
         prog_r <= `HTR_REG_RESET;
      end else begin
         if (wr_txd)  txd_r  <= REG_WDATA;
         if (wr_tone) tone_r <= REG_WDATA;
         if (wr_mask) mask_r <= REG_WDATA;
         if (wr_prog) prog_r <= REG_WDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) prog_stb_r <= 1'b0;
      else      prog_stb_r <= wr_prog;
   end

   // handshake: stage_r only changes while the link side has acked
   wire pend_ref = load_tgl_r ^ ack_s_r;
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         stage_r    <= '0;
         load_tgl_r <= 1'b0;
         dirty_r    <= 1'b0;
      end else if (!pend_ref && (wr_txd || dirty_r)) begin
         stage_r    <= wr_txd ? REG_WDATA[10:0] : txd_r[10:0];
         load_tgl_r <= ~load_tgl_r;
         dirty_r    <= 1'b0;
      end else if (wr_txd) begin
         dirty_r    <= 1'b1;
      end
   end

   // link events back to REF_CLK, toggles through two flops then edge
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         {ack_m_r, ack_s_r} <= 2'b00;
         {req_m_r, req_s_r, req_p_r} <= 3'b000;
         {end_m_r, end_s_r, end_p_r} <= 3'b000;
         en_ref_r <= 1'b0;
      end else begin
         ack_m_r  <= ack_tgl_r;
         ack_s_r  <= ack_m_r;
         req_m_r  <= req_tgl_r;
         req_s_r  <= req_m_r;
         req_p_r  <= req_s_r;
         end_m_r  <= end_tgl_r;
         end_s_r  <= end_m_r;
         end_p_r  <= end_s_r;
         en_ref_r <= MSK_TX_ENABLE;
      end
   end

   wire req_evt = req_s_r ^ req_p_r;
   wire end_evt = end_s_r ^ end_p_r;

   // ---------------- status and interrupt line ----------------
   wire [15:0] ev_all  = (EVENT_SET | ({8'h00, end_evt, req_evt, 6'h00} << 0))
                         & `HTR_EVENT_BITS;
   wire [15:0] ev_mask = ev_all & mask_r & `HTR_EVENT_BITS;
   wire [15:0] rd_clr  = rd_stat ? 16'hfffe : 16'h0000;
   wire [15:0] pg_clr  = wr_prog ? 16'h0001 : 16'h0000;

   // set wins over read or setup clear
   always_comb begin
      stat_nxt = (stat_r & ~(rd_clr | pg_clr)) | ev_all;
      if (ev_mask != 16'h0000) stat_nxt[`HTR_ST_IRQ] = 1'b1;
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         stat_r  <= `HTR_REG_RESET;
         irq_n_r <= 1'b1;
         rdata_r <= 16'h0000;
      end else begin
         stat_r  <= stat_nxt;
         irq_n_r <= !(stat_nxt[`HTR_ST_IRQ] && mask_r[`HTR_MASK_GATE]);
         rdata_r <= rd_stat ? stat_r : 16'h0000;
      end
   end

   // ---------------- tone generator ----------------
   logic [27:0] phase_r;
   logic [1:0]  tone_lvl_r;
   wire  [11:0] tone_hz  = tone_r[`HTR_TONE_MSB:0];
   wire  [28:0] ph_sum   = {1'b0, phase_r} + {17'h00000, tone_hz};
   wire         ph_wrap  = ph_sum >= {1'b0, CLK_HZ};
   wire  [27:0] ph_nxt   = ph_wrap ? 28'(ph_sum - {1'b0, CLK_HZ}) : ph_sum[27:0];
   wire         tone_on  = TONE_ENABLE && (tone_hz != 12'h000);

   // one wrap of the accumulator per second per count gives 1 hz per lsb
   always_ff @(posedge REF_CLK) begin
      if (SRST || !tone_on) begin
         phase_r    <= 28'h0000000;
         tone_lvl_r <= 2'h0;
      end else begin
         phase_r    <= ph_nxt;
         tone_lvl_r <= (phase_r >= HALF_HZ) ? 2'h3 : 2'h1;
      end
   end

   // ---------------- receive checker ----------------
   htr_crc #(.WIDTH(15), .POLY(CRC_POLY)) u_rx_crc (
      .clk   (REF_CLK),
      .rst   (SRST),
      .feed  (RX_BYTE_VALID),
      .clear (!txd_r[`HTR_TXD_CONT]),
      .data  (RX_BYTE),
      .crc_r (RX_CHECK_CRC),
      .par_r (RX_CHECK_PARITY)
   );

   // ---------------- link side, MOD_CLK ----------------
   logic        lrst_m_r, lrst_r;
   logic        ld_m_r, ld_s_r, en_m_r, en_s_r, en_p_r;
   logic        ack_tgl_r, req_tgl_r, end_tgl_r, mod_on_r;
   logic [2:0]  bit_r;
   logic [7:0]  sh_r, cur_r;
   logic        app_r;
   htr_pkg::htr_lstate_type st_r, st_nxt;
   logic [14:0] tx_crc;
   logic        tx_par;

   always_ff @(posedge MOD_CLK) begin
      lrst_m_r <= SRST;
      lrst_r   <= lrst_m_r;
   end

   always_ff @(posedge MOD_CLK) begin
      if (lrst_r) begin
         {ld_m_r, ld_s_r}         <= 2'b00;
         {en_m_r, en_s_r, en_p_r} <= 3'b000;
      end else begin
         ld_m_r <= load_tgl_r;
         ld_s_r <= ld_m_r;
         en_m_r <= en_ref_r;
         en_s_r <= en_m_r;
         en_p_r <= en_s_r;
      end
   end

   wire pend_l    = ld_s_r ^ ack_tgl_r;
   wire byte_end  = (bit_r == 3'h7);
   wire start     = (st_r == htr_pkg::HTR_L_IDLE) && en_s_r && !en_p_r;
   wire trail_due = (st_r == htr_pkg::HTR_L_DATA) && app_r;
   // next data byte chosen only at start or at a byte boundary
   wire pick      = start || (byte_end && !trail_due &&
                    (st_r == htr_pkg::HTR_L_DATA || st_r == htr_pkg::HTR_L_CRC_LO));
   wire take      = pick && (pend_l || start);
   // an idle link with the enable off acks at once, so the stage tracks the last write
   wire absorb    = (st_r == htr_pkg::HTR_L_IDLE) && !en_s_r && pend_l;
   wire go_hang   = take && stage_r[`HTR_TXD_LAST];
   wire take_byte = take && !stage_r[`HTR_TXD_LAST];
   wire crc_hi    = byte_end && trail_due;
   wire crc_lo    = byte_end && (st_r == htr_pkg::HTR_L_CRC_HI);

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         htr_pkg::HTR_L_IDLE:   if (start) st_nxt = go_hang ? htr_pkg::HTR_L_HANG
                                                            : htr_pkg::HTR_L_DATA;
         htr_pkg::HTR_L_DATA:   if (crc_hi) st_nxt = htr_pkg::HTR_L_CRC_HI;
                                else if (go_hang) st_nxt = htr_pkg::HTR_L_HANG;
         htr_pkg::HTR_L_CRC_HI: if (crc_lo) st_nxt = htr_pkg::HTR_L_CRC_LO;
         htr_pkg::HTR_L_CRC_LO: if (byte_end) st_nxt = go_hang ? htr_pkg::HTR_L_HANG
                                                               : htr_pkg::HTR_L_DATA;
         htr_pkg::HTR_L_HANG:   st_nxt = htr_pkg::HTR_L_IDLE;
         default:               st_nxt = htr_pkg::HTR_L_IDLE;
      endcase
      if (!en_s_r) st_nxt = htr_pkg::HTR_L_IDLE;
   end

   // a data byte enters the modulator and the generator together
   htr_crc #(.WIDTH(15), .POLY(CRC_POLY)) u_tx_crc (
      .clk   (MOD_CLK),
      .rst   (lrst_r),
      .feed  (take_byte),
      .clear (!stage_r[`HTR_TXD_CONT]),
      .data  (stage_r[7:0]),
      .crc_r (tx_crc),
      .par_r (tx_par)
   );

   wire       lo_par = tx_par ^ (^tx_crc);
   wire [7:0] sh_ld  = take_byte ? stage_r[7:0] :
                       crc_hi    ? tx_crc[14:7] :
                       crc_lo    ? {tx_crc[6:0], lo_par} : cur_r;

   always_ff @(posedge MOD_CLK) begin
      if (lrst_r) begin
         st_r      <= htr_pkg::HTR_L_IDLE;
         bit_r     <= 3'h0;
         sh_r      <= 8'h00;
         cur_r     <= 8'h00;
         app_r     <= 1'b0;
         ack_tgl_r <= 1'b0;
         req_tgl_r <= 1'b0;
         end_tgl_r <= 1'b0;
         mod_on_r  <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         mod_on_r <= (st_nxt != htr_pkg::HTR_L_IDLE);
         bit_r    <= (st_nxt == htr_pkg::HTR_L_DATA || st_nxt == htr_pkg::HTR_L_CRC_HI ||
                      st_nxt == htr_pkg::HTR_L_CRC_LO) && !pick && !crc_hi && !crc_lo
                     ? bit_r + 3'h1 : 3'h0;
         if ((take && pend_l) || absorb) ack_tgl_r <= ~ack_tgl_r;
         if ((take_byte && !stage_r[`HTR_TXD_APPEND]) || crc_lo)
            req_tgl_r <= ~req_tgl_r;
         if (st_r == htr_pkg::HTR_L_HANG) end_tgl_r <= ~end_tgl_r;
         if (take_byte) begin
            cur_r <= stage_r[7:0];
            app_r <= stage_r[`HTR_TXD_APPEND];
         end else if (pick) begin
            app_r <= 1'b0;
         end
         if (st_nxt == htr_pkg::HTR_L_IDLE)
            sh_r <= 8'h00;
         else if ((pick && !go_hang) || crc_hi || crc_lo)
            sh_r <= sh_ld;
         else if (st_nxt != htr_pkg::HTR_L_HANG)
            sh_r <= {sh_r[6:0], 1'b0};
      end
   end

   // hang bit repeats the last data bit, so sh_r[7] is kept
   assign MODULATOR_OUTPUTS     = sh_r[7];
   assign MOD_ACTIVE            = mod_on_r;
   assign TONE_LEVEL            = tone_lvl_r;
   assign REG_RDATA             = rdata_r;
   assign PROG_WORD             = prog_r;
   assign PROG_STROBE           = prog_stb_r;
   assign HOST_INTERRUPT_LINE_N = irq_n_r;

   // ---------------- checks, REF_CLK ----------------
   irq_gate_off_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      !mask_r[`HTR_MASK_GATE] |=> HOST_INTERRUPT_LINE_N)
      else $error("interrupt line active with gate off");

   irq_summary_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      (ev_mask != 16'h0000 && mask_r[`HTR_MASK_GATE]) |=>
      (stat_r[`HTR_ST_IRQ] && !HOST_INTERRUPT_LINE_N))
      else $error("masked event did not raise interrupt");

   selcall_rise_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      (EVENT_SET[`HTR_ST_SELCALL] && mask_r[`HTR_ST_SELCALL]) |=>
      (stat_r[`HTR_ST_SELCALL] && stat_r[`HTR_ST_IRQ]))
      else $error("selective-call event lost");

   status_read_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      (rd_stat && ev_all == 16'h0000) |=> (stat_r[15:1] == 15'h0000 &&
      stat_r[`HTR_ST_PROG] == $past(stat_r[`HTR_ST_PROG])))
      else $error("status read clear wrong");

   prog_clear_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      (wr_prog && !ev_all[`HTR_ST_PROG]) |=> !stat_r[`HTR_ST_PROG])
      else $error("setup write did not clear bit 0");

   txd_hold_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      !wr_txd |=> txd_r == $past(txd_r))
      else $error("transmit byte register changed without write");

   tone_write_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      wr_tone |=> tone_r == $past(REG_WDATA))
      else $error("tone write not applied");

   tone_bias_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      (tone_hz == 12'h000) |=> TONE_LEVEL == 2'h0)
      else $error("zero tone field not at bias");

   // ---------------- checks, MOD_CLK ----------------
   sequence trailer_s;
      (st_r == htr_pkg::HTR_L_CRC_HI) [*8] ##1 (st_r == htr_pkg::HTR_L_CRC_LO);
   endsequence

   crc_trailer_a: assert property (@(posedge MOD_CLK) disable iff (lrst_r)
      ($rose(st_r == htr_pkg::HTR_L_CRC_HI) && en_s_r) |->
      (trailer_s or ##[1:8] !en_s_r))
      else $error("checksum trailer not two bytes");

   crc_request_a: assert property (@(posedge MOD_CLK) disable iff (lrst_r)
      (crc_hi || (take_byte && stage_r[`HTR_TXD_APPEND])) |=> req_tgl_r == $past(req_tgl_r))
      else $error("request raised before checksum bytes");

   hang_end_a: assert property (@(posedge MOD_CLK) disable iff (lrst_r)
      (st_r == htr_pkg::HTR_L_HANG) |=>
      (st_r == htr_pkg::HTR_L_IDLE && end_tgl_r != $past(end_tgl_r)))
      else $error("hang bit not followed by transmit end");

   resend_a: assert property (@(posedge MOD_CLK) disable iff (lrst_r)
      (pick && !pend_l && st_r != htr_pkg::HTR_L_IDLE) |=> sh_r == $past(cur_r))
      else $error("held byte not resent");

endmodule : htr_regs

`default_nettype wire

// ---- bench/htr_host.sv ----
// host model: single-word writes and status reads on the register port
// assumes a rising-edge register port on clk, read data one cycle after the read
`timescale 1ns/1ps
`default_nettype none
`include "htr_defs.svh"

module htr_host (
   input  wire logic        clk,
   output logic             wr,
   output logic             rd,
   output logic [7:0]       addr,
   output logic [15:0]      wdata,
   input  wire logic [15:0] rdata
);
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
   end

   // callers keep reserved bits zero and tones within range
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      if (a != `HTR_ADDR_RSVD) begin
         @(posedge clk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
endmodule : htr_host
`default_nettype wire

// ---- bench/htr_tb_top.sv ----
// self-checking bench of the host register bank
// assumes htr_regs and the host model; link clock free-running at 12 ns
`timescale 1ns/1ps
`default_nettype none
`include "htr_defs.svh"

module host_tx_data_tone_irq_regs_tb_top;
   localparam logic [14:0] POLY = 15'h6815;
   logic        ref_clk;
   logic        mod_clk;
   logic        srst;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        msk_en;
   logic        tone_en;
   logic [15:0] ev;
   logic        rx_v;
   logic [7:0]  rx_b;
   logic [14:0] rx_crc;
   logic        rx_par;
   logic [15:0] prog_word;
   logic        prog_stb;
   logic [1:0]  tone_lvl;
   logic        mod_out;
   logic        mod_act;
   logic        irq_n;
   logic [15:0] d;
   logic        bits[$];
   int          err_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          stb_cnt = 0;

   htr_regs #(.CRC_POLY(POLY)) dut (
      .REF_CLK(ref_clk), .SRST(srst), .MOD_CLK(mod_clk),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .MSK_TX_ENABLE(msk_en), .TONE_ENABLE(tone_en), .EVENT_SET(ev),
      .RX_BYTE_VALID(rx_v), .RX_BYTE(rx_b), .RX_CHECK_CRC(rx_crc),
      .RX_CHECK_PARITY(rx_par), .PROG_WORD(prog_word), .PROG_STROBE(prog_stb),
      .TONE_LEVEL(tone_lvl), .MODULATOR_OUTPUTS(mod_out), .MOD_ACTIVE(mod_act),
      .HOST_INTERRUPT_LINE_N(irq_n));

   htr_host u_host (.clk(ref_clk), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
      .wdata(reg_wdata), .rdata(reg_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // phase offset keeps the link edges apart from the register clock
   initial begin
      mod_clk = 1'b0;
      #1.3;
      forever #6 mod_clk = ~mod_clk;
   end

   always @(posedge mod_clk) begin
      if (mod_act === 1'b1) begin
         bits.push_back(mod_out);
      end
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (prog_stb === 1'b1) begin
         stb_cnt <= stb_cnt + 1;
      end
      if (cycles == 100000) begin
         err_count++;
         $display("MISMATCH at %0t: timeout", $time);
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   function automatic logic [14:0] crc_byte(input logic [14:0] c, input logic [7:0] b);
      logic fb;
      for (int i = 7; i >= 0; i--) begin
         fb = c[14] ^ b[i];
         c = {c[13:0], 1'b0} ^ (fb ? POLY : 15'h0000);
      end
      return c;
   endfunction : crc_byte

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic pulse(input logic [15:0] v);
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= 16'h0000;
   endtask : pulse

   task automatic rx_feed(input logic [7:0] v);
      @(posedge ref_clk);
      rx_v <= 1'b1;
      rx_b <= v;
      @(posedge ref_clk);
      rx_v <= 1'b0;
      tick(2);
   endtask : rx_feed

   // polling reads clear status bits 15:1, so callers see only the final word
   task automatic wait_st(input int b);
      for (int n = 0; n < 300; n++) begin
         u_host.rd_reg(`HTR_ADDR_STATUS, d);
         if (d[b] === 1'b1) begin
            return;
         end
      end
      chk(d, 16'hffff, "status wait");
   endtask : wait_st

   task automatic t_reset();
      chk(prog_word, 16'h0000, "prog reset");
      chk({14'h0, tone_lvl}, 16'h0000, "tone reset");
      chk({15'h0, irq_n}, 16'h0001, "irq reset");
      u_host.rd_reg(`HTR_ADDR_STATUS, d);
      chk(d, 16'h0000, "status reset");
      $display("t_reset done");
   endtask : t_reset

   task automatic t_prog();
      int s;
      pulse(16'h0001);
      u_host.rd_reg(`HTR_ADDR_STATUS, d);
      u_host.rd_reg(`HTR_ADDR_STATUS, d);
      chk(d, 16'h0001, "flag kept by read");
      s = stb_cnt;
      u_host.wr_reg(`HTR_ADDR_PROG, 16'h8123);
      tick(3);
      chk(prog_word, 16'h8123, "prog word");
      chk(16'(stb_cnt - s), 16'h0001, "prog strobe");
      u_host.rd_reg(`HTR_ADDR_STATUS, d);
      chk(d, 16'h0000, "flag cleared by setup");
      u_host.wr_reg(8'hc9, 16'h5555);
      u_host.wr_reg(`HTR_ADDR_RSVD, 16'h5555);
      tick(3);
      chk(prog_word, 16'h8123, "unmapped write");
      chk(16'(stb_cnt - s), 16'h0001, "no strobe");
      $display("t_prog done");
   endtask : t_prog

   task automatic t_irq();
      int srcs[8] = '{13, 11, 10, 9, 8, 4, 3, 0};
      u_host.wr_reg(`HTR_ADDR_MASK, 16'h2000);
      pulse(16'h2000);
      tick(3);
      chk({15'h0, irq_n}, 16'h0001, "gate off");
      u_host.rd_reg(`HTR_ADDR_STATUS, d);
      chk(d, 16'ha000, "gated status");
      foreach (srcs[i]) begin
         u_host.wr_reg(`HTR_ADDR_MASK, 16'h8000 | (16'h0001 << srcs[i]));
         pulse(16'h0001 << srcs[i]);
         tick(3);
         chk({15'h0, irq_n}, 16'h0000, "line low");
         u_host.rd_reg(`HTR_ADDR_STATUS, d);
         chk(d, 16'h8000 | (16'h0001 << srcs[i]), "source status");
         tick(2);
         chk({15'h0, irq_n}, 16'h0001, "line after read");
      end
      u_host.wr_reg(`HTR_ADDR_PROG, 16'h0000);
      $display("t_irq done");
   endtask : t_irq

   task automatic t_tx();
      logic [14:0] c;
      logic [31:0] exp;
      c = crc_byte(15'h0000, 8'h3c);
      exp = {8'ha5, 8'h3c, c, ^{8'h3c, c}};
      bits.delete();
      u_host.wr_reg(`HTR_ADDR_MASK, 16'h8080);
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h00a5);
      @(posedge ref_clk);
      msk_en <= 1'b1;
      wait_st(`HTR_ST_DREQ);
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h023c);
      wait_st(`HTR_ST_DREQ);
      chk({15'h0, bits.size() >= 24}, 16'h0001, "request after trailer");
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h0155);
      wait_st(`HTR_ST_TXEND);
      chk(d & 16'h8080, 16'h8080, "tx end status");
      tick(10);
      chk({15'h0, mod_act}, 16'h0000, "modulator off");
      chk(16'(bits.size()), 16'd33, "bit count");
      for (int i = 0; i < 32; i++) begin
         chk({15'h0, bits[i]}, {15'h0, exp[31-i]}, "tx bit");
      end
      chk({15'h0, bits[32]}, {15'h0, exp[0]}, "hang bit");
      @(posedge ref_clk);
      msk_en <= 1'b0;
      $display("t_tx done");
   endtask : t_tx

   task automatic t_rx();
      logic [14:0] c;
      c = crc_byte(15'h0000, 8'h5b);
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h0000);
      rx_feed(8'h5b);
      chk({rx_par, rx_crc}, {1'b1, c}, "rx restart");
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h0400);
      rx_feed(8'hc3);
      chk({rx_par, rx_crc}, {1'b1, crc_byte(c, 8'hc3)}, "rx continue");
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h0000);
      rx_feed(8'hc3);
      chk({rx_par, rx_crc}, {1'b0, crc_byte(15'h0000, 8'hc3)}, "rx clear");
      rx_feed(8'h00);
      chk({rx_par, rx_crc}, 16'h0000, "rx zero");
      $display("t_rx done");
   endtask : t_rx

   // two loads while idle, then no refill: the last one must repeat
   task automatic t_resend();
      int n;
      logic [7:0] b;
      b = 8'h11;
      bits.delete();
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h0022);
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h0011);
      tick(40);
      @(posedge ref_clk);
      msk_en <= 1'b1;
      n = 0;
      while (bits.size() < 20 && n < 1000) begin
         tick(1);
         n++;
      end
      u_host.wr_reg(`HTR_ADDR_TXD, 16'h0100);
      wait_st(`HTR_ST_TXEND);
      tick(10);
      chk(16'(bits.size() % 8), 16'h0001, "resend length");
      chk({15'h0, bits.size() >= 25}, 16'h0001, "resend count");
      for (int i = 0; i < bits.size() - 1; i++) begin
         chk({15'h0, bits[i]}, {15'h0, b[7 - i % 8]}, "resent bit");
      end
      chk({15'h0, bits[bits.size() - 1]}, 16'h0001, "resend hang");
      @(posedge ref_clk);
      msk_en <= 1'b0;
      $display("t_resend done");
   endtask : t_resend

   task automatic t_tone();
      int n;
      logic [1:0] lv;
      @(posedge ref_clk);
      tone_en <= 1'b1;
      u_host.wr_reg(`HTR_ADDR_TONE, 16'h0000);
      tick(20);
      chk({14'h0, tone_lvl}, 16'h0000, "zero tone");
      u_host.wr_reg(`HTR_ADDR_TONE, 16'h0bb8);
      n = 0;
      while (tone_lvl === 2'b00 && n < 100) begin
         tick(1);
         n++;
      end
      for (int k = 0; k < 2; k++) begin
         n = 0;
         lv = tone_lvl;
         while (tone_lvl === lv && n < 50000) begin
            tick(1);
            n++;
         end
      end
      chk({15'h0, lv == 2'b01 || lv == 2'b11}, 16'h0001, "tone level");
      chk({15'h0, n >= 41660 && n <= 41673}, 16'h0001, "half period");
      u_host.wr_reg(`HTR_ADDR_TONE, 16'h0000);
      tick(2);
      chk({14'h0, tone_lvl}, 16'h0000, "tone change");
      @(posedge ref_clk);
      tone_en <= 1'b0;
      $display("t_tone done");
   endtask : t_tone

   initial begin
      srst = 1'b1;
      msk_en = 1'b0;
      tone_en = 1'b0;
      ev = 16'h0000;
      rx_v = 1'b0;
      rx_b = 8'h00;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      tick(20);
      t_reset();
      t_prog();
      t_irq();
      t_tx();
      t_rx();
      t_resend();
      t_tone();
      results();
   end
endmodule : host_tx_data_tone_irq_regs_tb_top
`default_nettype wire
